// ---- hw/inor_resolver.sv ----
// Natural order interrupt resolver, one clock, registered outputs
`timescale 1ns/1ps
module inor_resolver
    import inor_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SOURCES
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [N_SRC-1:0] source_pending_flags,
    input  wire logic [N_SRC-1:0] source_enable,
    input  wire logic [N_SRC-1:0] source_priority_level_select,
    input  wire logic             sw_irq_req,
    input  wire logic             dma_ch2_source_count_event,
    output logic                  irq_valid_r,
    output logic                  irq_high_r,
    output logic [VEC_W-1:0]      cpu_working_register_r
);

    // =================================================================
    // Sizing
    // =================================================================
    // Groups split one long priority chain into two short ones
    localparam int unsigned GRP_W   = 8;
    localparam int unsigned LOC_W   = $clog2(GRP_W);
    localparam int unsigned N_GRP   = (N_SRC + GRP_W - 1) / GRP_W;
    localparam int unsigned GIDX_W  = (N_GRP > 1) ? $clog2(N_GRP) : 1;
    localparam int unsigned N_PAD   = N_GRP * GRP_W;
    localparam int unsigned MAX_VEC = N_SRC - 1;

    // =================================================================
    // Elaboration checks
    // =================================================================
    // Both fixed sources need a slot of their own
    if (N_SRC < VEC_DMA2_SCNT + 1) begin : g_too_few_src
        $error("inor_resolver: N_SRC leaves no slot for the fixed sources");
    end

    // Every rank must fit the vector handed to the core
    if (MAX_VEC >= (1 << VEC_W)) begin : g_vec_too_narrow
        $error("inor_resolver: N_SRC exceeds what the vector can number");
    end

    // A group of one would leave the local index without bits
    if (GRP_W < 2) begin : g_grp_too_small
        $error("inor_resolver: GRP_W must be at least 2");
    end

    // =================================================================
    // Request gathering
    // =================================================================
    logic [N_SRC-1:0] req_raw;
    logic [N_SRC-1:0] req;

    // Only the two fixed slots have a dedicated line besides their flag
    function automatic logic inor_extra_line(
        input int unsigned slot,
        input logic        sw_line,
        input logic        dma_line
    );
        logic hit;
        hit = 1'b0;
        if (slot == VEC_SOFTWARE) begin
            hit = sw_line;
        end else if (slot == VEC_DMA2_SCNT) begin
            hit = dma_line;
        end
        return hit;
    endfunction

    for (genvar s = 0; s < N_SRC; s++) begin : g_src
        // Extra lines join before the enable, so a masked slot stays silent
        assign req_raw[s] = source_pending_flags[s]
                          | inor_extra_line(s, sw_irq_req, dma_ch2_source_count_event);
        assign req[s]     = req_raw[s] & source_enable[s];
    end

    // =================================================================
    // Level split
    // =================================================================
    logic [N_SRC-1:0] req_hi;
    logic [N_SRC-1:0] req_lo;

    for (genvar s = 0; s < N_SRC; s++) begin : g_level
        assign req_hi[s] = req[s] & (source_priority_level_select[s] == LEVEL_HIGH);
        assign req_lo[s] = req[s] & (source_priority_level_select[s] == LEVEL_LOW);
    end

    // =================================================================
    // Request summary
    // =================================================================
    logic any_req;
    logic any_hi;
    logic any_lo;

    assign any_req = |req;
    assign any_hi  = |req_hi;
    assign any_lo  = |req_lo;

    // =================================================================
    // Scan helpers
    // =================================================================
    // Lowest set bit of a group; scanned from the top so bit 0 is taken last
    function automatic logic [LOC_W-1:0] inor_first_loc(
        input logic [GRP_W-1:0] v
    );
        logic [LOC_W-1:0] idx;
        idx = {LOC_W{1'b0}};
        for (int i = GRP_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = LOC_W'(i);
            end
        end
        return idx;
    endfunction

    // Same search over the group summary bits
    function automatic logic [GIDX_W-1:0] inor_first_grp(
        input logic [N_GRP-1:0] v
    );
        logic [GIDX_W-1:0] idx;
        idx = {GIDX_W{1'b0}};
        for (int i = N_GRP - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = GIDX_W'(i);
            end
        end
        return idx;
    endfunction

    // =================================================================
    // Group scan
    // =================================================================
    logic [N_PAD-1:0] hi_pad;
    logic [N_PAD-1:0] lo_pad;
    logic [N_GRP-1:0] grp_any_hi;
    logic [N_GRP-1:0] grp_any_lo;
    logic [LOC_W-1:0] grp_loc_hi [N_GRP];
    logic [LOC_W-1:0] grp_loc_lo [N_GRP];

    // Padding costs a few constant bits but keeps every group the same width
    for (genvar p = 0; p < N_PAD; p++) begin : g_pad
        if (p < N_SRC) begin : g_live
            assign hi_pad[p] = req_hi[p];
            assign lo_pad[p] = req_lo[p];
        end else begin : g_fill
            assign hi_pad[p] = 1'b0;
            assign lo_pad[p] = 1'b0;
        end
    end

    for (genvar g = 0; g < N_GRP; g++) begin : g_grp
        // Each group resolves on its own; the next stage only picks a group
        assign grp_any_hi[g] = |hi_pad[g*GRP_W +: GRP_W];
        assign grp_any_lo[g] = |lo_pad[g*GRP_W +: GRP_W];
        assign grp_loc_hi[g] = inor_first_loc(hi_pad[g*GRP_W +: GRP_W]);
        assign grp_loc_lo[g] = inor_first_loc(lo_pad[g*GRP_W +: GRP_W]);
    end

    // =================================================================
    // Winner per level
    // =================================================================
    logic [GIDX_W-1:0] win_grp_hi;
    logic [GIDX_W-1:0] win_grp_lo;
    logic [VEC_W-1:0]  win_vec_hi;
    logic [VEC_W-1:0]  win_vec_lo;

    // The rank is the vector number itself, so no setting can reorder it
    function automatic logic [VEC_W-1:0] inor_join(
        input logic [GIDX_W-1:0] grp,
        input logic [LOC_W-1:0]  loc
    );
        int unsigned flat;
        flat = int'(grp) * GRP_W + int'(loc);
        return VEC_W'(flat);
    endfunction

    always_comb begin
        win_grp_hi = inor_first_grp(grp_any_hi);
        win_grp_lo = inor_first_grp(grp_any_lo);
        win_vec_hi = inor_join(win_grp_hi, grp_loc_hi[win_grp_hi]);
        win_vec_lo = inor_join(win_grp_lo, grp_loc_lo[win_grp_lo]);
    end

    // =================================================================
    // Resolution
    // =================================================================
    logic             valid_nxt;
    logic             high_nxt;
    logic [VEC_W-1:0] vec_nxt;

    always_comb begin
        // High level outranks low; order within a level is by vector only
        valid_nxt = any_req;
        high_nxt  = any_hi;

        if (any_hi) begin
            vec_nxt = win_vec_hi;
        end else if (any_lo) begin
            vec_nxt = win_vec_lo;
        end else begin
            // Idle keeps the last winner for a core that reads it late
            vec_nxt = cpu_working_register_r;
        end
    end

    // =================================================================
    // Output registers
    // =================================================================
    // One edge of latency buys outputs that come straight from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_valid_r            <= 1'b0;
            irq_high_r             <= 1'b0;
            cpu_working_register_r <= VEC_RESET;
        end else begin
            irq_valid_r            <= valid_nxt;
            irq_high_r             <= high_nxt;
            cpu_working_register_r <= vec_nxt;
        end
    end

endmodule

// ---- hw/inor_pkg.sv ----
// Package of constants for the natural order interrupt resolver
// =====================================================================
// =====================================================================
package inor_pkg;
    localparam int unsigned NUM_SOURCES   = 82;
    localparam int unsigned VEC_W         = 7;
    localparam int unsigned VEC_SOFTWARE  = 0;
    localparam int unsigned VEC_DMA2_SCNT = 42;
    localparam logic [6:0]  VEC_RESET     = 7'h00;
    localparam logic        LEVEL_HIGH    = 1'b1;
    localparam logic        LEVEL_LOW     = 1'b0;
endpackage

// ---- dv/inor_resolver_properties.sv ----
// Checker for the natural order resolver
`timescale 1ns/1ps
module inor_resolver_properties
    import inor_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SOURCES
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             sw_irq_req,
    input wire logic             dma_ch2_source_count_event,
    input wire logic             irq_valid_r,
    input wire logic             irq_high_r,
    input wire logic [N_SRC-1:0] source_pending_flags,
    input wire logic [N_SRC-1:0] source_enable,
    input wire logic [N_SRC-1:0] source_priority_level_select,
    input wire logic [VEC_W-1:0] cpu_working_register_r
);
    wire [N_SRC-1:0] rq = (source_pending_flags | N_SRC'(sw_irq_req)
        | (N_SRC'(dma_ch2_source_count_event) << VEC_DMA2_SCNT)) & source_enable;
    wire [N_SRC-1:0] hq = rq & source_priority_level_select;
    wire [N_SRC-1:0] lv = (|hq) ? hq : rq;
    wire [N_SRC-1:0] oh = lv & (~lv + 1'b1);
    wire any_rq = |rq;
    wire any_hq = |hq;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_reset_clear: assert property (disable iff (1'b0) rst |=> !irq_valid_r && !irq_high_r
        && cpu_working_register_r == 7'h00) else $error("outputs not cleared");
    chk_valid_req: assert property (!rst |=> irq_valid_r == $past(any_rq)) else $error("bad valid");
    chk_high_level: assert property (!rst && any_rq |=> irq_high_r == $past(any_hq)) else $error("bad level");
    chk_lowest_wins: assert property (!rst && any_rq |=> $past(oh) == (N_SRC'(1) << cpu_working_register_r))
        else $error("wrong winner");
    chk_idle_hold: assert property (!rst && !any_rq |=> $stable(cpu_working_register_r)) else $error("no hold");
    chk_sw_vector: assert property (!rst && sw_irq_req && source_enable[0] && !any_hq |=>
        cpu_working_register_r == VEC_SOFTWARE) else $error("software vector");
    chk_dma_vector: assert property (!rst && dma_ch2_source_count_event && !any_hq && rq[41:0] == '0
        && source_enable[VEC_DMA2_SCNT] |=> cpu_working_register_r == VEC_DMA2_SCNT) else $error("dma vector");
    chk_vec_range: assert property (irq_valid_r |-> cpu_working_register_r <= N_SRC - 1) else $error("range");
endmodule
bind inor_resolver inor_resolver_properties #(.N_SRC(N_SRC)) inor_resolver_properties_i (.ref_clk(ref_clk), .rst(rst),
    .sw_irq_req(sw_irq_req), .dma_ch2_source_count_event(dma_ch2_source_count_event), .irq_valid_r(irq_valid_r),
    .irq_high_r(irq_high_r), .source_pending_flags(source_pending_flags), .source_enable(source_enable),
    .source_priority_level_select(source_priority_level_select), .cpu_working_register_r(cpu_working_register_r));

// ---- dv/inor_core_model.sv ----
// Core model that takes the resolved vector
`timescale 1ns/1ps
module inor_core_model
    import inor_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             irq_valid_r,
    input  wire logic [VEC_W-1:0] cpu_working_register_r,
    output logic      [VEC_W-1:0] taken_vec
);
    always_ff @(posedge ref_clk) if (irq_valid_r) taken_vec <= cpu_working_register_r;
endmodule

// ---- dv/test_inor_resolver.sv ----
// Testbench for the natural order resolver
`timescale 1ns/1ps
module test_inor_resolver;
    import inor_pkg::*;
    logic ref_clk = 0, rst = 1, sw = 0, dma = 0, vld, hi;
    logic [81:0] fl = '0, en = '1, sel = '0;
    logic [6:0] vec, taken;
    int err_total = 0, n_tests = 0;
    always #50 ref_clk = ~ref_clk;
    inor_resolver inor_resolver_i (.ref_clk(ref_clk), .rst(rst), .source_pending_flags(fl), .source_enable(en),
        .source_priority_level_select(sel), .sw_irq_req(sw), .dma_ch2_source_count_event(dma),
        .irq_valid_r(vld), .irq_high_r(hi), .cpu_working_register_r(vec));
    inor_core_model inor_core_model_i (.ref_clk(ref_clk), .irq_valid_r(vld), .cpu_working_register_r(vec),
        .taken_vec(taken));
    task automatic check(input logic v, h, input logic [6:0] x);
        n_tests++;
        if (vld !== v || hi !== h || vec !== x) begin
            $display("Error at %0t: got %0b %0b %0d expected %0b %0b %0d", $time, vld, hi, vec, v, h, x);
            err_total++;
        end
    endtask
    task automatic step(input logic [81:0] f, s, input logic w, d, v, h, input logic [6:0] x);
        @(posedge ref_clk) begin fl <= f; sel <= s; sw <= w; dma <= d; end
        @(posedge ref_clk) #1 check(v, h, x);
    endtask
    task summarize;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_natural; step(82'h28, '0, 0, 0, 1, 0, 7'h03); endtask
    task t_level; step(82'h100_0000_0028, 82'h100_0000_0000, 0, 0, 1, 1, 7'h28); endtask
    task t_idle;
        step('0, '0, 0, 0, 0, 0, 7'h28);
        n_tests++;
        if (taken !== 7'h28) begin
            $display("Error at %0t: core took %0d", $time, taken);
            err_total++;
        end
    endtask
    task t_reset;
        @(posedge ref_clk) begin fl <= 82'h28; sw <= 0; dma <= 0; rst <= 1; end
        @(posedge ref_clk) #1 check(0, 0, 7'h00);
        @(posedge ref_clk) rst <= 0;
        @(posedge ref_clk) #1 check(1, 0, 7'h03);
    endtask
    task t_sw; step(82'h2_0000_0000_0000_0000_0000, '0, 1, 0, 1, 0, 7'h00); endtask
    task t_dma; step(82'h2_0000_0000_0800_0000_0000, '0, 0, 1, 1, 0, 7'h2a); endtask
    task t_mask;
        @(posedge ref_clk) en <= ~82'h8;
        step(82'h2_0000_0000_0000_0000_0008, '0, 0, 0, 1, 0, 7'h51);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        t_natural; t_level; t_idle; t_sw; t_dma; t_reset; t_mask;
        summarize;
    end
    initial begin #20000; err_total++; summarize; end
endmodule
